// ==== design/system_power_clock_control.sv ====
/*
 * System control: external interrupt routing and wake, vector mapping,
 * Idle and Power-down sequencing, peripheral power and peripheral clock divider.
 * Assumes an APB master on clk_sys (the cpu_clock) and clock gates downstream.
 */
// Overview of operation
// (RULE1) Nine pins, each edge or level sensitive
// (RULE2) Pins combine onto four interrupt lines
// (RULE3) Enabled lines wake from Power-down
// (RULE4) Mapping control redirects vectors at zero
// (RULE5) Vectors come from flash or SRAM
// (RULE6) Idle halts processor until reset or interrupt
// (RULE7) Idle keeps peripheral clocks, stops core clocks
// (RULE8) Power-down stops oscillator and all clocks
// (RULE9) Power-down retains state, output pins hold
// (RULE10) Power-down ends on reset or clockless interrupt
// (RULE11) Each peripheral can be powered off
// (RULE12) Peripheral clock divides by one, two, four
// (RULE13) Divider resets to one quarter
// (RULE14) PLL stays running through Idle
// (RULE15) PLL off and bypassed after reset
// (RULE16) New ratio applies at period boundary
`timescale 1ns/1ns
module system_power_clock_control (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External pins and peripheral interrupts
	input wire logic [syscon_pkg::NPIN-1:0] ext_pin,
	input wire logic periph_irq,
	// Interrupt lines to the core
	output logic [syscon_pkg::NLINE-1:0] eint_req,
	output logic irq,
	// Memory map, clock, pin hold and peripheral power controls
	output logic vec_from_sram,
	output logic cpu_clk_en,
	output logic pclk_en,
	output logic osc_en,
	output logic pll_enable,
	output logic pll_connect,
	output logic pin_hold,
	output logic [syscon_pkg::NPERIPH-1:0] periph_pwr
);
	logic [1:0] rsync_r; // Reset release flops
	logic rst_n_s; // Synchronised reset
	logic [syscon_pkg::NPIN-1:0] pin_lvl; // Filtered pin levels
	syscon_pkg::sys_state_t st_r; // All state
	syscon_pkg::sys_state_t st_nxt; // Next state
	logic [syscon_pkg::NLINE-1:0] line_hit; // Per-line event this cycle
	logic [syscon_pkg::NPIN-1:0] act; // Active-polarity level
	logic setup; // APB setup phase
	logic wr; // Write takes effect
	logic rd; // Read completes
	logic mapped; // Address decodes

	//////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rsync_r <= 2'h0;
		end else begin
			rsync_r <= {rsync_r[0], 1'b1};
		end
	end
	assign rst_n_s = rsync_r[1];

	// Pin synchroniser
	pin_sync i_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n_s),
		.pin_in(ext_pin),
		.pin_lvl(pin_lvl)
	);

	//////////////////////////////////////////////////////////////////
	// Divider terminal count per ratio; code three reads as quarter
	function automatic logic [1:0] term(input logic [1:0] sel);
		case (sel)
			syscon_pkg::DIV_FULL: term = 2'h0;
			syscon_pkg::DIV_HALF: term = 2'h1;
			default: term = 2'h3;
		endcase
	endfunction : term

	// Decode helpers
	assign setup = psel && !penable;
	assign wr = psel && penable && st_r.pready && pwrite;
	assign rd = psel && penable && st_r.pready && !pwrite;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= syscon_pkg::OFS_STATUS);

	//////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		line_hit = '0;
		act = pin_lvl ^ ~st_r.pol;
		// Pin detection and routing
		for (int i = 0; i < syscon_pkg::NPIN; i++) begin
			if (st_r.en[i] && (st_r.mode[i] ? (act[i] && !st_r.prev[i]) : act[i])) begin // RULE1
				line_hit[st_r.route[2*i +: 2]] = 1'b1; // RULE2
			end
		end
		st_nxt.prev = act;
		// Sticky flags; read clears only what was returned, set wins
		if (rd && paddr == syscon_pkg::OFS_INT_FLAG) begin
			st_nxt.flag = st_r.flag & ~st_r.prdata[syscon_pkg::NLINE-1:0];
		end
		st_nxt.flag = st_nxt.flag | line_hit; // RULE2
		st_nxt.req = st_nxt.flag & st_r.mask;
		st_nxt.irq = |(st_nxt.flag & st_r.mask);

		// Register writes at the access edge
		if (wr) begin
			case (paddr)
				syscon_pkg::OFS_EXT_EN: st_nxt.en = pwdata[syscon_pkg::NPIN-1:0];
				syscon_pkg::OFS_EXT_MODE: st_nxt.mode = pwdata[syscon_pkg::NPIN-1:0];
				syscon_pkg::OFS_EXT_POL: st_nxt.pol = pwdata[syscon_pkg::NPIN-1:0];
				syscon_pkg::OFS_EXT_ROUTE: st_nxt.route = pwdata[2*syscon_pkg::NPIN-1:0];
				syscon_pkg::OFS_EXT_WAKE: st_nxt.wake = pwdata[syscon_pkg::NLINE-1:0]; // RULE3
				syscon_pkg::OFS_INT_MASK: st_nxt.mask = pwdata[syscon_pkg::NLINE-1:0];
				syscon_pkg::OFS_VEC_MAP: st_nxt.map_sram = pwdata[0]; // RULE4 RULE5
				syscon_pkg::OFS_PERIPH_PWR: st_nxt.pconp = pwdata[syscon_pkg::NPERIPH-1:0]; // RULE11
				syscon_pkg::OFS_PCLK_DIV: st_nxt.div_sel = pwdata[1:0]; // RULE12
				syscon_pkg::OFS_PLL_CTRL: begin
					st_nxt.pll_en = pwdata[syscon_pkg::PLL_EN_BIT];
					st_nxt.pll_con = pwdata[syscon_pkg::PLL_CON_BIT];
				end
				default: begin
				end
			endcase
		end

		// Mode sequencing; Power-down wins over Idle in one write
		case (st_r.pm)
			syscon_pkg::PM_RUN: begin
				if (wr && paddr == syscon_pkg::OFS_PWR_MODE) begin
					if (pwdata[syscon_pkg::PWR_PDOWN_BIT]) begin
						st_nxt.pm = syscon_pkg::PM_PDOWN; // RULE8
					end else if (pwdata[syscon_pkg::PWR_IDLE_BIT]) begin
						st_nxt.pm = syscon_pkg::PM_IDLE; // RULE6
					end
				end
			end
			syscon_pkg::PM_IDLE: begin
				// Any interrupt ends Idle
				if (st_r.irq || periph_irq) begin
					st_nxt.pm = syscon_pkg::PM_RUN; // RULE6
				end
			end
			syscon_pkg::PM_PDOWN: begin
				// Only wake-enabled pin lines, detected without the divider
				if (|(line_hit & st_r.wake)) begin
					st_nxt.pm = syscon_pkg::PM_RUN; // RULE3 RULE10
				end
			end
			default: st_nxt.pm = syscon_pkg::PM_RUN;
		endcase

		// Clock and pin controls follow the next mode
		st_nxt.cpu_on = (st_nxt.pm == syscon_pkg::PM_RUN); // RULE6 RULE7
		st_nxt.osc_on = (st_nxt.pm != syscon_pkg::PM_PDOWN); // RULE8
		st_nxt.hold = (st_nxt.pm == syscon_pkg::PM_PDOWN); // RULE9
		st_nxt.pll_on = st_nxt.pll_en && st_nxt.osc_on; // RULE14 RULE15
		st_nxt.pll_use = st_nxt.pll_con && st_nxt.pll_on; // RULE15

		// Divider: ratio swaps only when a period completes
		st_nxt.pclk_en = 1'b0;
		if (st_nxt.pm != syscon_pkg::PM_PDOWN) begin // RULE7 RULE8
			if (st_r.cnt >= term(st_r.div_act)) begin
				st_nxt.cnt = 2'h0;
				st_nxt.div_act = st_nxt.div_sel; // RULE16
				st_nxt.pclk_en = 1'b1; // RULE12
			end else begin
				st_nxt.cnt = st_r.cnt + 2'h1;
			end
		end

		// APB answer prepared in setup, returned in one access cycle
		st_nxt.pready = setup;
		st_nxt.pslverr = setup && !mapped;
		st_nxt.prdata = '0;
		if (setup) begin
			case (paddr)
				syscon_pkg::OFS_EXT_EN: st_nxt.prdata[syscon_pkg::NPIN-1:0] = st_r.en;
				syscon_pkg::OFS_EXT_MODE: st_nxt.prdata[syscon_pkg::NPIN-1:0] = st_r.mode;
				syscon_pkg::OFS_EXT_POL: st_nxt.prdata[syscon_pkg::NPIN-1:0] = st_r.pol;
				syscon_pkg::OFS_EXT_ROUTE: st_nxt.prdata[2*syscon_pkg::NPIN-1:0] = st_r.route;
				syscon_pkg::OFS_EXT_WAKE: st_nxt.prdata[syscon_pkg::NLINE-1:0] = st_r.wake;
				syscon_pkg::OFS_INT_FLAG: st_nxt.prdata[syscon_pkg::NLINE-1:0] = st_r.flag;
				syscon_pkg::OFS_INT_MASK: st_nxt.prdata[syscon_pkg::NLINE-1:0] = st_r.mask;
				syscon_pkg::OFS_VEC_MAP: st_nxt.prdata[0] = st_r.map_sram;
				syscon_pkg::OFS_PWR_MODE: st_nxt.prdata[1:0] = st_r.pm;
				syscon_pkg::OFS_PERIPH_PWR: st_nxt.prdata[syscon_pkg::NPERIPH-1:0] = st_r.pconp;
				syscon_pkg::OFS_PCLK_DIV: st_nxt.prdata[1:0] = st_r.div_sel;
				syscon_pkg::OFS_PLL_CTRL: st_nxt.prdata[1:0] = {st_r.pll_con, st_r.pll_en};
				syscon_pkg::OFS_STATUS: st_nxt.prdata[3:0] = {st_r.div_act, st_r.pll_use, st_r.pll_on};
				default: st_nxt.prdata = '0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// State register; reset leaves PLL off, divider at quarter
	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_r <= syscon_pkg::ST_RESET; // RULE13 RULE15
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign eint_req = st_r.req;
	assign irq = st_r.irq;
	assign vec_from_sram = st_r.map_sram;
	assign cpu_clk_en = st_r.cpu_on;
	assign pclk_en = st_r.pclk_en;
	assign osc_en = st_r.osc_on;
	assign pll_enable = st_r.pll_on;
	assign pll_connect = st_r.pll_use;
	assign pin_hold = st_r.hold;
	assign periph_pwr = st_r.pconp;

	//////////////////////////////////////////////////////////////////
	// Checks
	property p_flag_set;
		@(posedge clk_sys) disable iff (!rst_n_s) line_hit[0] |=> st_r.flag[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("line event lost"); // RULE1

	property p_irq_lines;
		@(posedge clk_sys) disable iff (!rst_n_s) irq == |eint_req;
	endproperty
	a_irq_lines: assert property (p_irq_lines) else $error("irq disagrees with lines"); // RULE2

	property p_wake;
		@(posedge clk_sys) disable iff (!rst_n_s)
			(st_r.pm == syscon_pkg::PM_PDOWN) && |(line_hit & st_r.wake) |=> cpu_clk_en && osc_en;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from Power-down"); // RULE3

	property p_idle_cpu;
		@(posedge clk_sys) disable iff (!rst_n_s)
			(st_r.pm == syscon_pkg::PM_IDLE) |-> !cpu_clk_en && osc_en;
	endproperty
	a_idle_cpu: assert property (p_idle_cpu) else $error("core clock on in Idle"); // RULE6

	property p_idle_exit;
		@(posedge clk_sys) disable iff (!rst_n_s)
			(st_r.pm == syscon_pkg::PM_IDLE) && periph_irq |=> cpu_clk_en;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("Idle not ended"); // RULE6

	property p_idle_pclk;
		@(posedge clk_sys) disable iff (!rst_n_s)
			(st_r.pm == syscon_pkg::PM_IDLE) [*4] |->
			(pclk_en || $past(pclk_en) || $past(pclk_en, 2) || $past(pclk_en, 3));
	endproperty
	a_idle_pclk: assert property (p_idle_pclk) else $error("peripheral clock stopped"); // RULE7

	property p_pdown_off;
		@(posedge clk_sys) disable iff (!rst_n_s)
			pin_hold |-> !osc_en && !pclk_en && !cpu_clk_en && !pll_enable;
	endproperty
	a_pdown_off: assert property (p_pdown_off) else $error("clock alive in Power-down"); // RULE8

	property p_retain;
		@(posedge clk_sys) disable iff (!rst_n_s)
			pin_hold && !(|(line_hit & st_r.wake)) |=>
			pin_hold && $stable(periph_pwr) && $stable(vec_from_sram);
	endproperty
	a_retain: assert property (p_retain) else $error("state changed in Power-down"); // RULE9

	property p_map;
		@(posedge clk_sys) disable iff (!rst_n_s)
			wr && paddr == syscon_pkg::OFS_VEC_MAP |=> vec_from_sram == $past(pwdata[0]);
	endproperty
	a_map: assert property (p_map) else $error("vector map not applied"); // RULE4

	property p_pconp;
		@(posedge clk_sys) disable iff (!rst_n_s)
			wr && paddr == syscon_pkg::OFS_PERIPH_PWR |=> periph_pwr == $past(pwdata[15:0]);
	endproperty
	a_pconp: assert property (p_pconp) else $error("peripheral power not applied"); // RULE11

	property p_div_rst;
		@(posedge clk_sys) disable iff (!rst_n_s)
			$rose(rsync_r[1]) |-> st_r.div_sel == syscon_pkg::DIV_QUARTER && !pll_enable && !pll_connect;
	endproperty
	a_div_rst: assert property (p_div_rst) else $error("bad reset clocking"); // RULE13

	property p_pll_idle;
		@(posedge clk_sys) disable iff (!rst_n_s)
			(st_r.pm == syscon_pkg::PM_IDLE) && st_r.pll_en |-> pll_enable;
	endproperty
	a_pll_idle: assert property (p_pll_idle) else $error("PLL stopped in Idle"); // RULE14

	property p_quarter;
		@(posedge clk_sys) disable iff (!rst_n_s)
			pclk_en && st_r.div_act == syscon_pkg::DIV_QUARTER |=> !pclk_en [*3];
	endproperty
	a_quarter: assert property (p_quarter) else $error("short peripheral clock period"); // RULE16

	c_idle: cover property (@(posedge clk_sys) disable iff (!rst_n_s)
		(st_r.pm == syscon_pkg::PM_IDLE) ##1 cpu_clk_en);
	c_wake: cover property (@(posedge clk_sys) disable iff (!rst_n_s)
		pin_hold ##1 !pin_hold);
	c_div: cover property (@(posedge clk_sys) disable iff (!rst_n_s)
		$changed(st_r.div_act));
endmodule : system_power_clock_control

// ==== design/syscon_pkg.sv ====
/*
 * Shared constants and carrier types of the system power and clock control.
 * Assumes a 32-bit APB with 12-bit byte addresses and one word per register.
 */
package syscon_pkg;
	// Pin, line and peripheral counts
	localparam int NPIN = 9;
	localparam int NLINE = 4;
	localparam int NPERIPH = 16;

	// Register byte offsets
	localparam logic [11:0] OFS_EXT_EN = 12'h000;
	localparam logic [11:0] OFS_EXT_MODE = 12'h004;
	localparam logic [11:0] OFS_EXT_POL = 12'h008;
	localparam logic [11:0] OFS_EXT_ROUTE = 12'h00c;
	localparam logic [11:0] OFS_EXT_WAKE = 12'h010;
	localparam logic [11:0] OFS_INT_FLAG = 12'h014;
	localparam logic [11:0] OFS_INT_MASK = 12'h018;
	localparam logic [11:0] OFS_VEC_MAP = 12'h01c;
	localparam logic [11:0] OFS_PWR_MODE = 12'h020;
	localparam logic [11:0] OFS_PERIPH_PWR = 12'h024;
	localparam logic [11:0] OFS_PCLK_DIV = 12'h028;
	localparam logic [11:0] OFS_PLL_CTRL = 12'h02c;
	localparam logic [11:0] OFS_STATUS = 12'h030;

	// Field positions
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_PDOWN_BIT = 1;
	localparam int PLL_EN_BIT = 0;
	localparam int PLL_CON_BIT = 1;

	// Divider encodings
	localparam logic [1:0] DIV_QUARTER = 2'h0;
	localparam logic [1:0] DIV_FULL = 2'h1;
	localparam logic [1:0] DIV_HALF = 2'h2;

	// Reset values
	localparam logic [NPERIPH-1:0] PERIPH_PWR_RST = 16'hffff;
	localparam logic [1:0] PCLK_DIV_RST = DIV_QUARTER;

	// Operating modes
	typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PDOWN} pmode_t;

	// Whole state of the control block
	typedef struct packed {
		logic [NPIN-1:0] en;
		logic [NPIN-1:0] mode;
		logic [NPIN-1:0] pol;
		logic [2*NPIN-1:0] route;
		logic [NLINE-1:0] wake;
		logic [NLINE-1:0] flag;
		logic [NLINE-1:0] mask;
		logic map_sram;
		logic [NPERIPH-1:0] pconp;
		logic [1:0] div_sel;
		logic [1:0] div_act;
		logic [1:0] cnt;
		logic pll_en;
		logic pll_con;
		pmode_t pm;
		logic [NPIN-1:0] prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [NLINE-1:0] req;
		logic irq;
		logic pclk_en;
		logic cpu_on;
		logic osc_on;
		logic pll_on;
		logic pll_use;
		logic hold;
	} sys_state_t;

	localparam sys_state_t ST_RESET = '{
		pconp: PERIPH_PWR_RST,
		div_sel: PCLK_DIV_RST,
		div_act: PCLK_DIV_RST,
		pm: PM_RUN,
		cpu_on: 1'b1,
		osc_on: 1'b1,
		default: '0
	};

	// Synchroniser state
	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [NPIN-1:0] s3;
		logic [NPIN-1:0] q;
	} sync_state_t;
endpackage : syscon_pkg

// ==== design/pin_sync.sv ====
/*
 * Three-stage synchroniser with agreement filter for the interrupt pins.
 * Assumes pins are asynchronous to clk_sys; reset is already synchronised.
 */
`timescale 1ns/1ns
module pin_sync (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Raw pins and clean levels
	input wire logic [syscon_pkg::NPIN-1:0] pin_in,
	output logic [syscon_pkg::NPIN-1:0] pin_lvl
);
	syscon_pkg::sync_state_t st_r; // All flops
	syscon_pkg::sync_state_t st_nxt; // Next value
	logic [syscon_pkg::NPIN-1:0] q_nxt; // Filtered level

	//////////////////////////////////////////////////////////////////
	// Per-pin filter: change counts once stages two and three agree
	for (genvar i = 0; i < syscon_pkg::NPIN; i++) begin : g_bit
		assign q_nxt[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s2[i] : st_r.q[i];
	end

	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1; // Stage one feeds nothing else
		st_nxt.s3 = st_r.s2;
		st_nxt.q = q_nxt;
	end

	// Registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_lvl = st_r.q;
endmodule : pin_sync

// ==== verification/periph_peer.sv ====
/*
 * Stand-in for a clocked peripheral that raises its interrupt line.
 * Assumes clk_sys and the pclk_en tick of the block under test.
 */
`timescale 1ns/1ns
module periph_peer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Peripheral clock tick and bench request
	input wire logic pclk_en,
	input wire logic arm,
	// Interrupt back to the block
	output logic periph_irq
);
	logic [1:0] cnt_r; // Ticks seen since armed

	////////////////////////////////////////////////////////////////////////
	// Counts only on peripheral ticks, so it stalls if the divider stops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			periph_irq <= 1'b0;
		end else if (!arm) begin
			// Idle: no request pending
			cnt_r <= 2'h0;
			periph_irq <= 1'b0;
		end else if (cnt_r == 2'h3) begin
			periph_irq <= 1'b1; // Level until disarmed
		end else if (pclk_en) begin
			cnt_r <= cnt_r + 2'h1;
		end
	end
endmodule : periph_peer

// ==== verification/tb_system_power_clock_control.sv ====
/*
 * Self-checking bench of the system power and clock control.
 * Assumes an APB slave that answers on the 20 MHz clk_sys, in its own time.
 */
`timescale 1ns/1ns
module tb_system_power_clock_control;
	logic clk_sys, reset_n, psel, penable, pwrite, arm, periph_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, rerr, irq, vec_from_sram, cpu_clk_en, pclk_en;
	logic osc_en, pll_enable, pll_connect, pin_hold;
	logic [8:0] ext_pin;
	logic [3:0] eint_req;
	logic [15:0] periph_pwr;
	logic [7:0] obs;
	int n_fail = 0;
	int check_count = 0;
	assign obs = {pin_hold, irq, eint_req, cpu_clk_en, osc_en};

	system_power_clock_control i_system_power_clock_control (.clk_sys(clk_sys),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_pin(ext_pin), .periph_irq(periph_irq),
		.eint_req(eint_req), .irq(irq), .vec_from_sram(vec_from_sram),
		.cpu_clk_en(cpu_clk_en), .pclk_en(pclk_en), .osc_en(osc_en),
		.pll_enable(pll_enable), .pll_connect(pll_connect), .pin_hold(pin_hold),
		.periph_pwr(periph_pwr));
	periph_peer i_periph_peer (.clk_sys(clk_sys), .rst_n(reset_n), .pclk_en(pclk_en),
		.arm(arm), .periph_irq(periph_irq));

	////////////////////////////////////////////////////////////////////////
	// Clock, 50 ns period
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// One APB transfer; entered just after a rising edge, leaves one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Waits as long as the slave needs; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		chk({31'h0, pready}, 32'h1, "pready");
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp, what);
	endtask : rd

	// Bounded wait for a pattern on the observed outputs
	task automatic wait_obs(input logic [7:0] m, input logic [7:0] v, input string what);
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_sys);
			if ((obs & m) === v)
				break;
		end
		chk({24'h0, obs & m}, {24'h0, v}, what);
	endtask : wait_obs

	// Cycles between two peripheral ticks
	task automatic period(output int n);
		int g;
		g = 0;
		do begin
			@(posedge clk_sys);
			g++;
		end while (pclk_en !== 1'b1 && g < 20);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pclk_en !== 1'b1 && n < 20);
	endtask : period

	////////////////////////////////////////////////////////////////////////
	// Reset values and peripheral power
	task automatic t_reset;
		int n;
		chk({16'h0, periph_pwr}, 32'hffff, "pwr rst");
		chk({30'h0, pll_enable, pll_connect}, 32'h0, "pll rst");
		chk({31'h0, vec_from_sram}, 32'h0, "vec flash");
		rd(syscon_pkg::OFS_STATUS, 32'h0, "status rst");
		period(n);
		chk(n, 4, "rst ratio");
		wr(syscon_pkg::OFS_PERIPH_PWR, 32'h00a5);
		chk({16'h0, periph_pwr}, 32'h00a5, "pwr off");
		wr(syscon_pkg::OFS_VEC_MAP, 32'h1);
		chk({31'h0, vec_from_sram}, 32'h1, "vec sram");
		rd(syscon_pkg::OFS_VEC_MAP, 32'h1, "vec rd");
		apb(1'b0, 12'h034, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h80000000, "unmapped");
		$display("test reset done");
	endtask : t_reset

	// Every divide ratio, applied whole periods
	task automatic t_div;
		logic [1:0] dv [4] = '{syscon_pkg::DIV_FULL, syscon_pkg::DIV_HALF, 2'h3,
			syscon_pkg::DIV_QUARTER};
		int per [4] = '{1, 2, 4, 4};
		int n;
		for (int k = 0; k < 4; k++) begin
			wr(syscon_pkg::OFS_PCLK_DIV, {30'h0, dv[k]});
			period(n);
			period(n);
			chk(n, per[k], "ratio");
			rd(syscon_pkg::OFS_STATUS, {28'h0, dv[k], 2'h0}, "div act");
		end
		$display("test divider done");
	endtask : t_div

	// Edge pin on each line, masking, level pin
	task automatic t_eint;
		// Polarity and edge mode first: enabling a low-active level pin would latch a flag
		wr(syscon_pkg::OFS_EXT_POL, 32'h1);
		wr(syscon_pkg::OFS_EXT_MODE, 32'h1);
		wr(syscon_pkg::OFS_EXT_EN, 32'h1);
		wr(syscon_pkg::OFS_INT_MASK, 32'hf);
		for (int k = 0; k < 4; k++) begin
			wr(syscon_pkg::OFS_EXT_ROUTE, k);
			ext_pin[0] <= 1'b1;
			wait_obs(8'h7c, 8'h40 | (8'h04 << k), "line");
			rd(syscon_pkg::OFS_INT_FLAG, 32'h1 << k, "flag");
			ext_pin[0] <= 1'b0;
			wait_obs(8'h7c, 8'h00, "clear");
		end
		wr(syscon_pkg::OFS_INT_MASK, 32'h0);
		ext_pin[0] <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk({24'h0, obs & 8'h7c}, 32'h0, "masked");
		rd(syscon_pkg::OFS_INT_FLAG, 32'h8, "sticky");
		rd(syscon_pkg::OFS_INT_FLAG, 32'h0, "read clr");
		wr(syscon_pkg::OFS_EXT_MODE, 32'h0);
		wr(syscon_pkg::OFS_INT_MASK, 32'h8);
		wait_obs(8'h7c, 8'h60, "level");
		rd(syscon_pkg::OFS_INT_FLAG, 32'h8, "lvl 1");
		rd(syscon_pkg::OFS_INT_FLAG, 32'h8, "lvl again");
		ext_pin[0] <= 1'b0;
		wr(syscon_pkg::OFS_EXT_MODE, 32'h1);
		apb(1'b0, syscon_pkg::OFS_INT_FLAG, 32'h0);
		rd(syscon_pkg::OFS_INT_FLAG, 32'h0, "lvl gone");
		$display("test interrupts done");
	endtask : t_eint

	// Idle ended by a peripheral, PLL kept running
	task automatic t_idle;
		int n;
		wr(syscon_pkg::OFS_PLL_CTRL, 32'h3);
		wr(syscon_pkg::OFS_PWR_MODE, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, cpu_clk_en}, 32'h0, "idle core");
		chk({30'h0, pll_enable, pll_connect}, 32'h3, "idle pll");
		period(n);
		chk(n, 4, "idle pclk");
		arm <= 1'b1;
		wait_obs(8'h02, 8'h02, "idle exit");
		arm <= 1'b0;
		$display("test idle done");
	endtask : t_idle

	// Power-down, state held, pin wake
	task automatic t_pdown;
		int n;
		wr(syscon_pkg::OFS_EXT_ROUTE, 32'h0);
		wr(syscon_pkg::OFS_EXT_WAKE, 32'h1);
		wr(syscon_pkg::OFS_PWR_MODE, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk({24'h0, obs & 8'h83}, 32'h80, "pdown");
		chk({31'h0, pll_enable}, 32'h0, "pdown pll");
		n = 0;
		repeat (12) begin
			@(posedge clk_sys);
			// Counts unknowns too, so a floating tick cannot pass
			if (pclk_en !== 1'b0)
				n++;
		end
		chk(n, 0, "pdown pclk");
		chk({15'h0, vec_from_sram, periph_pwr}, 32'h100a5, "retain");
		ext_pin[0] <= 1'b1;
		wait_obs(8'h83, 8'h03, "wake");
		chk({30'h0, pll_enable, pll_connect}, 32'h3, "pll back");
		ext_pin[0] <= 1'b0;
		$display("test power-down done");
	endtask : t_pdown

	// Power-down ended by a mid-run reset, reset values back
	task automatic t_wake_reset;
		wr(syscon_pkg::OFS_PWR_MODE, 32'h2);
		chk({24'h0, obs & 8'h83}, 32'h80, "pdown again");
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk({24'h0, obs & 8'h83}, 32'h03, "reset wake");
		chk({31'h0, vec_from_sram}, 32'h0, "reset map");
		chk({30'h0, pll_enable, pll_connect}, 32'h0, "reset pll");
		rd(syscon_pkg::OFS_PCLK_DIV, 32'h0, "reset div");
		$display("test reset wake done");
	endtask : t_wake_reset

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset_n, psel, penable, pwrite, arm} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_pin = 9'h000;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_div();
		t_eint();
		t_idle();
		t_pdown();
		t_wake_reset();
		wrap_up();
	end

	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#1000000;
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : tb_system_power_clock_control
